// ===== hdl/board_irq.sv
// Board interrupt gathering, strap routing and eight-level priority resolution.
//
// Behaviour
// - Nested mode: level 0 most urgent, 7 least.
// - Rotating mode: serviced level becomes least urgent.
// - Specific mode: software picks least urgent level.
// - Poll register shows highest pending level encoded.
// - AC-low pin becomes power-fail interrupt source.
// - Memory-protect low blocks all RAM access.
// - Unanswered bus command raises fail-safe interrupt.
// - Line clock pin is an interrupt source.
// - Serial transmit-empty and receive-full sources.
// - Parallel port gives three interrupt sources.
// - Timer 0 and 1 outputs are sources.
// - Two expansion connectors give four sources.
// - Eight active-low system bus request lines.
// - Backplane external and coprocessor error sources.
// - Any source strapped to any level or NMI.
// - Mask byte: set bit suppresses its level.
// - NMI bypasses controller and mask entirely.
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module board_irq
    import irq_pkg::*;
#(
    parameter int FAILSAFE_CYCLES = FAILSAFE_CYC
) (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output var  logic [DATA_W-1:0] rd_data,
    input  wire logic [7:0]        sys_irq_n,
    input  wire logic [2:0]        par_irq,
    input  wire logic [1:0]        ser_irq,
    input  wire logic [1:0]        tmr_out,
    input  wire logic [3:0]        exp_irq,
    input  wire logic              ac_low_n,
    input  wire logic              line_clk,
    input  wire logic              ext_irq,
    input  wire logic              coproc_err,
    input  wire logic              mem_protect_n,
    input  wire logic              bus_cmd,
    input  wire logic              bus_ack_n,
    input  wire logic              ram_req,
    output var  logic              ram_en,
    input  wire logic              int_ack,
    output var  logic              int_req,
    output var  vec_t              vec_out,
    output var  logic              nmi,
    output var  logic              irq
);
    localparam int SYNC_W = 26;
    // Idle levels at reset keep the edge detectors from seeing a false edge.
    localparam logic [SYNC_W-1:0] SYNC_RST = {3'b101, 3'b000, 1'b1, 11'h000, 8'hff};
    localparam int FS_W = $clog2(FAILSAFE_CYCLES + 1);
    localparam logic [FS_W-1:0] FS_LAST = FS_W'(FAILSAFE_CYCLES - 1);

    logic [SYNC_W-1:0] pins_s;
    logic [NUM_SRC-1:0] src;
    logic              prot_s_n;
    logic              cmd_s;
    logic              ack_s_n;
    logic              pwr_prev_r;

    ctrl_t             ctrl_r;
    logic [7:0]        mask_r;
    logic [EV_W-1:0]   ev_stat_r;
    logic [EV_W-1:0]   ev_mask_r;
    logic [95:0]       route_r;
    logic [7:0]        irr_r;
    logic [7:0]        isr_r;
    logic [7:0]        lvl_prev_r;
    logic [2:0]        rot_low_r;
    logic              nmi_prev_r;
    logic [FS_W-1:0]   fs_cnt_r;
    logic              fs_pulse_r;

    logic [7:0]        lvl_in;
    logic              nmi_in;
    logic [2:0]        low_lvl;
    logic [3:0]        pend_hit;
    logic [3:0]        isr_hit;
    logic              issue;
    logic              eoi_wr;
    logic [EV_W-1:0]   ev_set;

    // Raw pins are never read before both synchroniser stages.
    pin_sync #(
        .W       (SYNC_W),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .clock (clock),
        .rst_n (rst_n),
        .d     ({bus_ack_n,
                 bus_cmd,
                 mem_protect_n,
                 coproc_err,
                 ext_irq,
                 line_clk,
                 ac_low_n,
                 exp_irq,
                 tmr_out,
                 ser_irq,
                 par_irq,
                 sys_irq_n}),
        .q     (pins_s)
    );

    assign ack_s_n  = pins_s[25];
    assign cmd_s    = pins_s[24];
    assign prot_s_n = pins_s[23];

    // The system bus lines are active low and are inverted here.
    assign src[SRC_BUS +: 8] = ~pins_s[7:0];
    assign src[SRC_PAR +: 3] = pins_s[10:8];
    assign src[SRC_SER +: 2] = pins_s[12:11];
    assign src[SRC_TMR +: 2] = pins_s[14:13];
    assign src[SRC_EXP +: 4] = pins_s[18:15];
    assign src[SRC_FS]       = fs_pulse_r;
    assign src[SRC_PWR]      = ~pins_s[19];
    assign src[SRC_LINE]     = pins_s[20];
    assign src[SRC_EXT]      = pins_s[21];
    assign src[SRC_COP]      = pins_s[22];

    // Strap matrix: four bits per source, 0 to 7 a level, 8 the NMI, others open.
    always_comb begin
        lvl_in = 8'h00;
        nmi_in = 1'b0;
        for (int s = 0; s < NUM_SRC; s++) begin
            if (route_r[s*ROUTE_W +: ROUTE_W] == ROUTE_NMI) begin
                nmi_in = nmi_in | src[s];
            end else if (route_r[s*ROUTE_W + 3] == 1'b0) begin
                lvl_in[route_r[s*ROUTE_W +: 3]] = lvl_in[route_r[s*ROUTE_W +: 3]] | src[s];
            end
        end
    end

    // Least urgent level is picked per mode; unknown codes fall back to nested.
    always_comb begin
        case (ctrl_r.mode)
            MODE_ROTATE:   low_lvl = rot_low_r;
            MODE_SPECIFIC: low_lvl = ctrl_r.spec_low;
            default:       low_lvl = LOW_NESTED;
        endcase
    end

    // Scans upward from the level after the least urgent one.
    function automatic logic [3:0] first_from(input logic [7:0] v, input logic [2:0] low);
        logic [2:0] idx;
        logic [3:0] hit;
        hit = 4'h0;
        for (int i = 1; i <= NUM_LVL; i++) begin
            idx = low + 3'(i);
            if (!hit[3] && v[idx]) begin
                hit = {1'b1, idx};
            end
        end
        return hit;
    endfunction

    function automatic logic [2:0] rank(input logic [2:0] l, input logic [2:0] low);
        return 3'(l - low - 3'h1);
    endfunction

    assign pend_hit = first_from(irr_r & ~mask_r, low_lvl);
    assign isr_hit  = first_from(isr_r, low_lvl);

    // A request interrupts service only when it outranks every level in service.
    assign issue = pend_hit[3] &&
                   (!isr_hit[3] || rank(pend_hit[2:0], low_lvl) < rank(isr_hit[2:0], low_lvl));
    assign eoi_wr = wr_en && addr == OFS_EOI;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_r    <= CTRL_RST;
            mask_r    <= MASK_RST;
            ev_mask_r <= '0;
            route_r   <= {ROUTE_RST, ROUTE_RST, ROUTE_RST};
        end else if (wr_en) begin
            case (addr)
                OFS_CTRL:   ctrl_r    <= ctrl_t'(wr_data[11:0]);
                OFS_MASK:   mask_r    <= wr_data[7:0];
                OFS_EVMASK: ev_mask_r <= wr_data[EV_W-1:0];
                OFS_ROUTE0: route_r[31:0]  <= wr_data;
                OFS_ROUTE1: route_r[63:32] <= wr_data;
                OFS_ROUTE2: route_r[95:64] <= wr_data;
                default: ;
            endcase
        end
    end

    // Requests are caught on the rising edge of each level; a new edge wins over the
    // clear made by an acknowledge in the same cycle.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lvl_prev_r <= 8'h00;
            irr_r      <= 8'h00;
        end else begin
            lvl_prev_r <= lvl_in;
            irr_r <= (irr_r & ~((int_ack && issue) ? (8'h01 << pend_hit[2:0]) : 8'h00))
                     | (lvl_in & ~lvl_prev_r);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            isr_r     <= 8'h00;
            rot_low_r <= LOW_NESTED;
            int_req   <= 1'b0;
            vec_out   <= '0;
        end else begin
            // Polled mode never raises the CPU line; software reads the poll register.
            int_req <= issue && ctrl_r.mode != MODE_POLLED && !int_ack;
            vec_out.valid <= int_ack;
            if (int_ack) begin
                // With nothing to grant, the least urgent vector answers as spurious.
                vec_out.vector <= {ctrl_r.vbase, issue ? pend_hit[2:0] : low_lvl};
            end
            if (int_ack && issue) begin
                isr_r <= isr_r | (8'h01 << pend_hit[2:0]);
            end else if (eoi_wr && isr_hit[3]) begin
                isr_r     <= isr_r & ~(8'h01 << isr_hit[2:0]);
                rot_low_r <= isr_hit[2:0];
            end
        end
    end

    // The fail-safe counter holds at its end so one command gives one pulse.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fs_cnt_r   <= '0;
            fs_pulse_r <= 1'b0;
        end else begin
            fs_pulse_r <= 1'b0;
            if (!cmd_s || !ack_s_n) begin
                fs_cnt_r <= '0;
            end else if (fs_cnt_r != FS_LAST) begin
                fs_cnt_r <= fs_cnt_r + FS_W'(1);
                fs_pulse_r <= fs_cnt_r == FS_LAST - FS_W'(1);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ram_en <= 1'b0;
            nmi    <= 1'b0;
        end else begin
            ram_en <= ram_req && prot_s_n;
            nmi    <= nmi_in;
        end
    end

    always_comb begin
        ev_set            = '0;
        ev_set[EV_FS]     = fs_pulse_r;
        ev_set[EV_PWR]    = src[SRC_PWR] && !pwr_prev_r;
        ev_set[EV_RAMBLK] = ram_req && !prot_s_n;
        ev_set[EV_NMI]    = nmi_in && !nmi_prev_r;
    end

    // Write one to clear; an event in the same cycle keeps its bit set.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ev_stat_r  <= '0;
            pwr_prev_r <= 1'b0;
            nmi_prev_r <= 1'b0;
            irq        <= 1'b0;
        end else begin
            pwr_prev_r <= src[SRC_PWR];
            nmi_prev_r <= nmi_in;
            ev_stat_r  <= (ev_stat_r & ~((wr_en && addr == OFS_EVSTAT) ?
                           wr_data[EV_W-1:0] : '0)) | ev_set;
            irq        <= |(ev_stat_r & ev_mask_r);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (rd_en) begin
            case (addr)
                OFS_CTRL:   rd_data <= 32'(ctrl_r);
                OFS_MASK:   rd_data <= 32'(mask_r);
                OFS_EVSTAT: rd_data <= 32'(ev_stat_r);
                OFS_EVMASK: rd_data <= 32'(ev_mask_r);
                OFS_POLL:   rd_data <= 32'(pend_hit[3] ? (POLL_VALID | 8'(pend_hit[2:0]))
                                                       : 8'h00);
                OFS_LEVELS: rd_data <= {16'h0000, isr_r, irr_r};
                OFS_ROUTE0: rd_data <= route_r[31:0];
                OFS_ROUTE1: rd_data <= route_r[63:32];
                OFS_ROUTE2: rd_data <= route_r[95:64];
                default:    rd_data <= '0;
            endcase
        end else begin
            rd_data <= '0;
        end
    end
endmodule : board_irq
`default_nettype wire

// ===== hdl/irq_pkg.sv
// Shared constants and types of the board interrupt priority logic.
package irq_pkg;
    localparam int NUM_SRC   = 24;
    localparam int NUM_LVL   = 8;
    localparam int ADDR_W    = 6;
    localparam int DATA_W    = 32;
    localparam int ROUTE_W   = 4;
    localparam int EV_W      = 4;

    localparam logic [5:0] OFS_CTRL    = 6'h00;
    localparam logic [5:0] OFS_MASK    = 6'h04;
    localparam logic [5:0] OFS_EVSTAT  = 6'h08;
    localparam logic [5:0] OFS_EVMASK  = 6'h0c;
    localparam logic [5:0] OFS_POLL    = 6'h10;
    localparam logic [5:0] OFS_LEVELS  = 6'h14;
    localparam logic [5:0] OFS_EOI     = 6'h18;
    localparam logic [5:0] OFS_ROUTE0  = 6'h1c;
    localparam logic [5:0] OFS_ROUTE1  = 6'h20;
    localparam logic [5:0] OFS_ROUTE2  = 6'h24;

    localparam logic [3:0]  ROUTE_NMI   = 4'h8;
    localparam logic [31:0] ROUTE_RST   = 32'hffff_ffff;
    localparam logic [7:0]  MASK_RST    = 8'hff;
    localparam logic [2:0]  LOW_NESTED  = 3'h7;
    localparam logic [7:0]  POLL_VALID  = 8'h80;

    localparam int SRC_BUS   = 0;
    localparam int SRC_PAR   = 8;
    localparam int SRC_SER   = 11;
    localparam int SRC_TMR   = 13;
    localparam int SRC_EXP   = 15;
    localparam int SRC_FS    = 19;
    localparam int SRC_PWR   = 20;
    localparam int SRC_LINE  = 21;
    localparam int SRC_EXT   = 22;
    localparam int SRC_COP   = 23;

    localparam int EV_FS     = 0;
    localparam int EV_PWR    = 1;
    localparam int EV_RAMBLK = 2;
    localparam int EV_NMI    = 3;

    localparam int CLK_MHZ         = 100;
    localparam int FAILSAFE_MIN_US = 6000;
    localparam int FAILSAFE_MAX_US = 10000;
    localparam int FAILSAFE_CYC    = FAILSAFE_MIN_US * CLK_MHZ;

    typedef enum logic [3:0] {
        MODE_NESTED   = 4'b0001,
        MODE_ROTATE   = 4'b0010,
        MODE_SPECIFIC = 4'b0100,
        MODE_POLLED   = 4'b1000
    } mode_t;

    typedef struct packed {
        logic [4:0] vbase;
        logic [2:0] spec_low;
        logic [3:0] mode;
    } ctrl_t;

    localparam ctrl_t CTRL_RST = '{vbase: 5'h00, spec_low: 3'h7, mode: 4'b0001};

    typedef struct packed {
        logic       valid;
        logic [7:0] vector;
    } vec_t;
endpackage : irq_pkg

// ===== hdl/pin_sync.sv
// Two-flip-flop synchroniser for a vector of asynchronous pins.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : pin_sync
`default_nettype wire

// ===== test/board_irq_monitor.sv
// Port-level assertions for the board interrupt priority logic.
`timescale 1ns/10ps
`default_nettype none
module board_irq_monitor
    import irq_pkg::*;
#(
    parameter int FAILSAFE_CYCLES = FAILSAFE_CYC
) (
    input wire logic              clock,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              wr_en,
    input wire logic              rd_en,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic              mem_protect_n,
    input wire logic              ram_req,
    input wire logic              ram_en,
    input wire logic              int_ack,
    input wire logic              int_req,
    input wire vec_t              vec_out
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    sequence ack_taken_s;
        int_ack;
    endsequence
    sequence vec_pulse_s;
        vec_out.valid ##1 !vec_out.valid;
    endsequence
    ack_vec_a: assert property (ack_taken_s |=> vec_pulse_s)
        else $error("vector not presented after acknowledge");
    vec_spur_a: assert property (!int_ack |=> !vec_out.valid)
        else $error("vector valid without acknowledge");
    vec_hold_a: assert property (!$past(int_ack) |-> $stable(vec_out.vector))
        else $error("vector changed without acknowledge");
    // Writes and the acknowledge are the only things allowed to withdraw a request.
    req_hold_a: assert property (int_req && !int_ack && !$past(int_ack) && !wr_en
        && !$past(wr_en) |=> int_req)
        else $error("interrupt request dropped without cause");
    rd_idle_a: assert property (!$past(rd_en) |-> rd_data == '0)
        else $error("read data not zero outside a read");
    rd_unmapped_a: assert property (rd_en && (addr > OFS_ROUTE2 || addr[1:0] != 2'h0)
        |=> rd_data == '0)
        else $error("unmapped read returned data");
    ram_gate_a: assert property (ram_en |-> $past(ram_req))
        else $error("memory enabled without request");
    ram_block_a: assert property (!mem_protect_n [*4] |-> !ram_en)
        else $error("memory enabled while protected");
    ram_open_a: assert property ((mem_protect_n && ram_req) [*4] |=> ram_en)
        else $error("memory request not granted");
endmodule : board_irq_monitor
bind board_irq board_irq_monitor #(.FAILSAFE_CYCLES(FAILSAFE_CYCLES)) board_irq_monitor_inst (
    .clock, .rst_n, .addr, .wr_en, .rd_en, .rd_data, .mem_protect_n, .ram_req, .ram_en,
    .int_ack, .int_req, .vec_out
);
`default_nettype wire

// ===== test/cpu_model.sv
// Behavioural host processor that acknowledges interrupt requests.
`timescale 1ns/10ps
`default_nettype none
module cpu_model
    import irq_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic int_req,
    input  wire vec_t vec_out,
    output var  logic int_ack,
    output var  int   n_ack,
    output var  vec_t last_vec
);
    logic slow;
    initial begin
        int_ack = 1'b0;
        n_ack = 0;
        last_vec = '0;
        slow = 1'b0;
    end
    // Alternating prompt and slow answers checks that a request holds while waiting.
    always begin
        @(posedge clock);
        if (rst_n === 1'b1 && int_req === 1'b1) begin
            repeat (slow ? 3 : 0) @(posedge clock);
            int_ack <= 1'b1;
            @(posedge clock);
            int_ack <= 1'b0;
            @(posedge clock);
            last_vec = vec_out;
            n_ack++;
            slow = ~slow;
        end
    end
endmodule : cpu_model
`default_nettype wire

// ===== test/tb.sv
// Self-checking testbench for the board interrupt priority logic.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import irq_pkg::*;
    logic              clock, rst_n, wr_en, rd_en, mem_protect_n, bus_cmd, bus_ack_n;
    logic              ram_req, ram_en, int_ack, int_req, nmi, irq;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data, rd_data;
    logic [23:0]       src;
    vec_t              vec_out, last_vec;
    int                n_ack, acks, n_errors, checks_done;
    board_irq #(.FAILSAFE_CYCLES(20)) board_irq_inst (
        .clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .sys_irq_n(~src[7:0]), .par_irq(src[10:8]),
        .ser_irq(src[12:11]), .tmr_out(src[14:13]), .exp_irq(src[18:15]),
        .ac_low_n(~src[20]), .line_clk(src[21]), .ext_irq(src[22]), .coproc_err(src[23]),
        .mem_protect_n(mem_protect_n), .bus_cmd(bus_cmd), .bus_ack_n(bus_ack_n),
        .ram_req(ram_req), .ram_en(ram_en), .int_ack(int_ack), .int_req(int_req),
        .vec_out(vec_out), .nmi(nmi), .irq(irq)
    );
    cpu_model cpu_model_inst (
        .clock(clock), .rst_n(rst_n), .int_req(int_req), .vec_out(vec_out),
        .int_ack(int_ack), .n_ack(n_ack), .last_vec(last_vec)
    );
    always #5 clock = ~clock;
    task automatic wrap_up;
        $display("mismatches %0d of %0d checks", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc
    // The extra edge keeps a strobe from being lowered and raised in one step.
    task automatic wreg(input logic [5:0] a, input logic [31:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        cyc(1);
        wr_en <= 1'b0;
        cyc(1);
    endtask : wreg
    task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
        addr <= a;
        rd_en <= 1'b1;
        cyc(1);
        rd_en <= 1'b0;
        cyc(1);
        chk(rd_data, exp);
    endtask : rchk
    task automatic serve(input logic [8:0] exp);
        int i;
        i = 0;
        while (n_ack == acks && i < 300) begin
            cyc(1);
            i++;
        end
        if (i == 300) begin
            n_errors++;
            wrap_up();
        end else begin
            acks = n_ack;
            chk({23'h0, last_vec}, {23'h0, exp});
            wreg(OFS_EOI, 32'h0);
        end
    endtask : serve
    initial begin
        {clock, rst_n, wr_en, rd_en, bus_cmd, ram_req, addr, wr_data, src} = '0;
        {mem_protect_n, bus_ack_n} = 2'b11;
        {acks, n_errors, checks_done} = '0;
        cyc(20);
        rst_n <= 1'b1;
        rchk(OFS_CTRL, 32'(CTRL_RST));
        rchk(OFS_MASK, 32'(MASK_RST));
        rchk(OFS_ROUTE1, ROUTE_RST);
        rchk(6'h3c, 32'h0);
        wreg(OFS_POLL, 32'hffffffff);
        rchk(OFS_POLL, 32'h0);
        wreg(OFS_ROUTE0, 32'h76543210);
        wreg(OFS_MASK, 32'h0);
        wreg(OFS_CTRL, 32'h81);
        src <= 24'h24;
        serve(9'h10a);
        serve(9'h10d);
        src <= '0;
        wreg(OFS_MASK, 32'h4);
        src <= 24'h4;
        cyc(10);
        chk(int_req, 1'b0);
        wreg(OFS_MASK, 32'h0);
        serve(9'h10a);
        src <= '0;
        wreg(OFS_CTRL, 32'h88);
        src <= 24'h48;
        cyc(10);
        chk(int_req, 1'b0);
        rchk(OFS_POLL, 32'h83);
        wreg(OFS_CTRL, 32'h81);
        serve(9'h10b);
        serve(9'h10e);
        src <= '0;
        wreg(OFS_CTRL, 32'h82);
        src <= 24'h2;
        serve(9'h109);
        src <= '0;
        cyc(3);
        src <= 24'h5;
        serve(9'h10a);
        serve(9'h108);
        src <= '0;
        wreg(OFS_CTRL, 32'hb4);
        src <= 24'h28;
        serve(9'h10d);
        serve(9'h10b);
        src <= '0;
        wreg(OFS_CTRL, 32'h81);
        for (int s = 8; s < 24; s++) begin
            if (s != 19) begin
                for (int r = 0; r < 3; r++) begin
                    wreg(6'(OFS_ROUTE0 + 4 * r), (r == s / 8) ? ~(32'hb << 4 * (s % 8))
                        : ROUTE_RST);
                end
                src <= 24'h1 << s;
                serve(9'h10c);
                src <= '0;
                cyc(3);
            end
        end
        wreg(OFS_EVSTAT, 32'hf);
        wreg(OFS_EVMASK, 32'ha);
        wreg(OFS_ROUTE2, 32'h8fffffff);
        wreg(OFS_MASK, 32'hff);
        src <= 24'h900000;
        cyc(6);
        chk(nmi, 1'b1);
        chk(int_req, 1'b0);
        rchk(OFS_EVSTAT, 32'ha);
        chk(irq, 1'b1);
        wreg(OFS_EVSTAT, 32'h2);
        rchk(OFS_EVSTAT, 32'h8);
        wreg(OFS_EVMASK, 32'h2);
        cyc(2);
        chk(irq, 1'b0);
        src <= '0;
        cyc(6);
        chk(nmi, 1'b0);
        wreg(OFS_EVSTAT, 32'h8);
        ram_req <= 1'b1;
        cyc(5);
        chk(ram_en, 1'b1);
        mem_protect_n <= 1'b0;
        cyc(5);
        chk(ram_en, 1'b0);
        rchk(OFS_EVSTAT, 32'h4);
        {mem_protect_n, ram_req} <= 2'b10;
        cyc(5);
        wreg(OFS_EVSTAT, 32'hf);
        wreg(OFS_EVMASK, 32'h1);
        bus_cmd <= 1'b1;
        cyc(8);
        bus_ack_n <= 1'b0;
        cyc(40);
        rchk(OFS_EVSTAT, 32'h0);
        {bus_cmd, bus_ack_n} <= 2'b01;
        cyc(4);
        bus_cmd <= 1'b1;
        cyc(40);
        rchk(OFS_EVSTAT, 32'h1);
        chk(irq, 1'b1);
        wrap_up();
    end
endmodule : tb
`default_nettype wire
